// File: modbus_pkg.sv
// Purpose: Constants, states and CRC step for the RTU slave engine
// Assumes: Frame bytes arrive from a UART on the same clock
// Notes:   Codes, positions and lengths of the frame are named here once; buffer depth is set in the handler
//
// Overview of operation
// - CRC accumulator starts at all ones
// - CRC covers address byte through last data
// - Read returns consecutive registers from start
// - Register words travel upper byte first
// - Byte count equals twice register quantity
// - Exception: addr, func+80H, code, CRC
// - Single write stores value, echoes command
// - Loopback returns the command unchanged
// - Multi write fills ascending registers
// - Multi write reply: addr, func, start, qty
// - Station zero is broadcast, never answered
// - Exception reply is five bytes
package modbus_pkg;

   // ----------------------------------------
   // CRC
   // ----------------------------------------
   localparam logic [15:0] CRC_PRESET = 16'hFFFF;
   localparam logic [15:0] CRC_POLY   = 16'hA001;

   // ----------------------------------------
   // Function and exception codes
   // ----------------------------------------
   localparam logic [7:0] FN_READ      = 8'h03;
   localparam logic [7:0] FN_WRITE1    = 8'h06;
   localparam logic [7:0] FN_LOOP      = 8'h08;
   localparam logic [7:0] FN_WRITEN    = 8'h10;
   localparam logic [7:0] EXC_FLAG     = 8'h80;
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
   localparam logic [7:0] EXC_BAD_DATA = 8'h03;
   localparam logic [7:0] BCAST_ADDR   = 8'h00;

   // ----------------------------------------
   // Frame layout, byte positions and lengths
   // ----------------------------------------
   localparam int POS_ADDR  = 0;
   localparam int POS_FN    = 1;
   localparam int POS_START = 2;
   localparam int POS_QTY   = 4;
   localparam int POS_BC    = 6;
   localparam int POS_WN    = 7;
   localparam int POS_W1    = 4;
   localparam int RD_HDR    = 3;
   localparam int FIXED_LEN = 8;
   localparam int WN_FIXED  = 9;
   localparam int ECHO_LEN  = 6;
   localparam int EXC_LEN   = 3;
   localparam int MIN_FRAME = 4;

   typedef enum logic [2:0] {
      S_RX   = 3'b000,
      S_EVAL = 3'b001,
      S_WR   = 3'b010,
      S_RD   = 3'b011,
      S_SEND = 3'b100
   } state_t;

   // One byte through the reflected CRC, LSB first
   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0]  d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

endpackage

// File: modbus_rtu_slave_handler.sv
// Purpose: RTU slave frame checker, command decoder and reply builder
// Assumes: Byte stream and frame end come from logic on clock_i
// Notes:   Half duplex; bytes arriving outside receive are dropped
`timescale 1ns/1ns
module modbus_rtu_slave_handler #(
   parameter int MAX_REGS = 16
)(
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  station_addr_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_end_i,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   output logic             tx_last_o,
   input  wire logic        tx_ready_i,
   output logic             reg_we_o,
   output logic             reg_re_o,
   output logic [15:0]      reg_addr_o,
   output logic [15:0]      reg_wdata_o,
   input  wire logic [15:0] reg_rdata_i,
   output logic             crc_err_o
);

   // ----------------------------------------
   // Storage and state
   // ----------------------------------------
   localparam int DEPTH = 9 + 2 * MAX_REGS;
   localparam int IW    = $clog2(DEPTH + 3);

   modbus_pkg::state_t state_q;
   modbus_pkg::state_t ev_go;
   logic [7:0]         buf_q [DEPTH];
   logic [IW-1:0]      cnt_q;
   logic [IW-1:0]      pos_q;
   logic [IW-1:0]      len_q;
   logic [IW-1:0]      k_q;
   logic [15:0]        n_q;
   logic [15:0]        start_q;
   logic [15:0]        rx_crc_q;
   logic [15:0]        tx_crc_q;
   logic [15:0]        tx_crc_n;
   logic               ovf_q;
   logic               bcast_q;
   logic               exc_q;
   logic               phase_q;
   logic [7:0]         ev_code;

   // ----------------------------------------
   // Frame evaluation
   // ----------------------------------------
   wire [7:0]  fn     = buf_q[modbus_pkg::POS_FN];
   wire [7:0]  adr    = buf_q[modbus_pkg::POS_ADDR];
   wire [15:0] st_w   = {buf_q[modbus_pkg::POS_START],
                         buf_q[modbus_pkg::POS_START+1]};
   wire [15:0] qt_w   = {buf_q[modbus_pkg::POS_QTY],
                         buf_q[modbus_pkg::POS_QTY+1]};
   wire [7:0]  bc_w   = buf_q[modbus_pkg::POS_BC];
   wire [15:0] cnt16  = 16'(cnt_q);
   wire        bcast  = adr == modbus_pkg::BCAST_ADDR;
   wire        crc_ok = rx_crc_q == 16'h0000;
   wire        long_e = cnt_q >= IW'(modbus_pkg::MIN_FRAME);
   wire        fixed  = cnt_q == IW'(modbus_pkg::FIXED_LEN);
   wire        qty_ok = qt_w != 16'h0000 && qt_w <= 16'(MAX_REGS);
   wire        bc_ok  = bc_w == {qt_w[6:0], 1'b0};
   wire        wn_len = cnt16 == 16'(modbus_pkg::WN_FIXED) + {8'h00, bc_w};
   // Station zero in our own setting disables replies and actions
   wire        mine   = station_addr_i != 8'h00
                        && (bcast || adr == station_addr_i);
   wire        frame_ok = crc_ok && long_e && !ovf_q && mine;

   always_comb begin
      ev_code = 8'h00;
      ev_go   = modbus_pkg::S_RX;
      case (fn)
         modbus_pkg::FN_READ: begin
            if (!fixed || !qty_ok) ev_code = modbus_pkg::EXC_BAD_DATA;
            else ev_go = modbus_pkg::S_RD;
         end
         modbus_pkg::FN_WRITE1: begin
            if (!fixed) ev_code = modbus_pkg::EXC_BAD_DATA;
            else ev_go = modbus_pkg::S_WR;
         end
         modbus_pkg::FN_LOOP: begin
            if (!fixed) ev_code = modbus_pkg::EXC_BAD_DATA;
            else ev_go = modbus_pkg::S_SEND;
         end
         modbus_pkg::FN_WRITEN: begin
            if (!qty_ok || !bc_ok || !wn_len) begin
               ev_code = modbus_pkg::EXC_BAD_DATA;
            end else begin
               ev_go = modbus_pkg::S_WR;
            end
         end
         default: ev_code = modbus_pkg::EXC_BAD_FUNC;
      endcase
      if (ev_code != 8'h00) ev_go = modbus_pkg::S_SEND;
      // Broadcasts still write, but never read or answer
      if (bcast && ev_go != modbus_pkg::S_WR) begin
         ev_go = modbus_pkg::S_RX;
      end
      if (!frame_ok) begin
         ev_go   = modbus_pkg::S_RX;
         ev_code = 8'h00;
      end
   end

   assign tx_crc_n = modbus_pkg::crc_byte(tx_crc_q, tx_data_o);

   // ----------------------------------------
   // Main sequencer
   // ----------------------------------------
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_q    <= modbus_pkg::S_RX;
         for (int i = 0; i < DEPTH; i++) buf_q[i] <= 8'h00;
         cnt_q      <= '0;
         pos_q      <= '0;
         len_q      <= '0;
         k_q        <= '0;
         n_q        <= 16'h0000;
         start_q    <= 16'h0000;
         rx_crc_q   <= modbus_pkg::CRC_PRESET;
         tx_crc_q   <= modbus_pkg::CRC_PRESET;
         ovf_q      <= 1'b0;
         bcast_q    <= 1'b0;
         exc_q      <= 1'b0;
         phase_q    <= 1'b0;
         tx_valid_o <= 1'b0;
         tx_data_o  <= 8'h00;
         tx_last_o  <= 1'b0;
         reg_we_o   <= 1'b0;
         reg_re_o   <= 1'b0;
         reg_addr_o <= 16'h0000;
         reg_wdata_o <= 16'h0000;
         crc_err_o  <= 1'b0;
      end else begin
         reg_we_o  <= 1'b0;
         reg_re_o  <= 1'b0;
         crc_err_o <= 1'b0;
         case (state_q)
            modbus_pkg::S_RX: begin
               if (rx_end_i) begin
                  state_q <= modbus_pkg::S_EVAL;
               end else if (rx_valid_i) begin
                  // Overlong frames are counted out, then dropped
                  if (cnt_q < IW'(DEPTH)) begin
                     buf_q[cnt_q] <= rx_data_i;
                     cnt_q        <= cnt_q + 1'b1;
                  end else begin
                     ovf_q <= 1'b1;
                  end
                  rx_crc_q <= modbus_pkg::crc_byte(rx_crc_q, rx_data_i);
               end
            end
            modbus_pkg::S_EVAL: begin
               state_q   <= ev_go;
               crc_err_o <= long_e && !crc_ok;
               cnt_q     <= '0;
               ovf_q     <= 1'b0;
               rx_crc_q  <= modbus_pkg::CRC_PRESET;
               tx_crc_q  <= modbus_pkg::CRC_PRESET;
               start_q   <= st_w;
               bcast_q   <= bcast;
               exc_q     <= ev_code != 8'h00;
               k_q       <= '0;
               phase_q   <= 1'b0;
               n_q       <= (fn == modbus_pkg::FN_WRITE1) ? 16'h0001 : qt_w;
               if (ev_code != 8'h00) begin
                  buf_q[modbus_pkg::POS_FN]    <= fn | modbus_pkg::EXC_FLAG;
                  buf_q[modbus_pkg::POS_START] <= ev_code;
                  len_q <= IW'(modbus_pkg::EXC_LEN);
                  pos_q <= '0;
               end else if (fn == modbus_pkg::FN_READ) begin
                  buf_q[modbus_pkg::POS_START] <= {qt_w[6:0], 1'b0};
                  len_q <= IW'(modbus_pkg::RD_HDR) + {qt_w[IW-2:0], 1'b0};
                  pos_q <= IW'(modbus_pkg::RD_HDR);
               end else begin
                  len_q <= IW'(modbus_pkg::ECHO_LEN);
                  pos_q <= (fn == modbus_pkg::FN_WRITEN)
                           ? IW'(modbus_pkg::POS_WN)
                           : (fn == modbus_pkg::FN_WRITE1)
                           ? IW'(modbus_pkg::POS_W1) : '0;
               end
            end
            modbus_pkg::S_WR: begin
               reg_we_o    <= 1'b1;
               reg_addr_o  <= start_q + 16'(k_q);
               reg_wdata_o <= {buf_q[pos_q], buf_q[pos_q+1'b1]};
               pos_q       <= pos_q + 2'd2;
               k_q         <= k_q + 1'b1;
               if (16'(k_q) + 16'h0001 == n_q) begin
                  state_q <= bcast_q ? modbus_pkg::S_RX
                                     : modbus_pkg::S_SEND;
                  pos_q   <= '0;
               end
            end
            modbus_pkg::S_RD: begin
               if (!phase_q) begin
                  reg_re_o   <= 1'b1;
                  reg_addr_o <= start_q + 16'(k_q);
                  phase_q    <= 1'b1;
               end else begin
                  buf_q[pos_q]      <= reg_rdata_i[15:8];
                  buf_q[pos_q+1'b1] <= reg_rdata_i[7:0];
                  pos_q   <= pos_q + 2'd2;
                  k_q     <= k_q + 1'b1;
                  phase_q <= 1'b0;
                  if (16'(k_q) + 16'h0001 == n_q) begin
                     state_q <= modbus_pkg::S_SEND;
                     pos_q   <= '0;
                  end
               end
            end
            modbus_pkg::S_SEND: begin
               if (!tx_valid_o) begin
                  tx_valid_o <= 1'b1;
                  tx_data_o  <= buf_q[pos_q];
               end else if (tx_ready_i) begin
                  pos_q <= pos_q + 1'b1;
                  if (pos_q < len_q) begin
                     tx_crc_q <= tx_crc_n;
                     tx_data_o <= (pos_q + 1'b1 < len_q)
                                  ? buf_q[pos_q+1'b1]
                                  : tx_crc_n[7:0];
                  end else if (pos_q == len_q) begin
                     tx_data_o <= tx_crc_q[15:8];
                     tx_last_o <= 1'b1;
                  end else begin
                     tx_valid_o <= 1'b0;
                     tx_last_o  <= 1'b0;
                     state_q    <= modbus_pkg::S_RX;
                  end
               end
            end
            default: state_q <= modbus_pkg::S_RX;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   a_crc_preset_rx: assert property (
      state_q == modbus_pkg::S_RX && cnt_q == '0 && !ovf_q
      |-> rx_crc_q == modbus_pkg::CRC_PRESET)
      else $error("receive CRC not preset");

   a_crc_preset_tx: assert property (
      state_q == modbus_pkg::S_SEND && !tx_valid_o
      |-> tx_crc_q == modbus_pkg::CRC_PRESET)
      else $error("transmit CRC not preset");

   a_crc_low_first: assert property (
      tx_valid_o && pos_q == len_q |-> tx_data_o == tx_crc_q[7:0]
      ##0 !tx_last_o)
      else $error("CRC low byte misplaced");

   a_crc_high_last: assert property (
      tx_valid_o && tx_last_o
      |-> tx_data_o == tx_crc_q[15:8] && pos_q == len_q + 1'b1)
      else $error("CRC high byte misplaced");

   a_read_addr_seq: assert property (
      reg_re_o |-> reg_addr_o == start_q + 16'(k_q)
      && state_q == modbus_pkg::S_RD)
      else $error("read address out of sequence");

   a_read_upper: assert property (
      reg_re_o |=> buf_q[$past(pos_q)] == $past(reg_rdata_i[15:8]))
      else $error("read word not stored upper first");

   a_read_count: assert property (
      state_q == modbus_pkg::S_RD
      |-> buf_q[modbus_pkg::POS_START] == {n_q[6:0], 1'b0})
      else $error("byte count not twice quantity");

   a_write_seq: assert property (
      reg_we_o |-> reg_addr_o == start_q + 16'(k_q) - 16'h0001)
      else $error("write address out of sequence");

   a_exc_shape: assert property (
      tx_valid_o && exc_q |-> len_q == IW'(modbus_pkg::EXC_LEN)
      && buf_q[modbus_pkg::POS_FN][7])
      else $error("exception reply malformed");

   a_echo_shape: assert property (
      tx_valid_o && !exc_q && buf_q[modbus_pkg::POS_FN] !=
      modbus_pkg::FN_READ |-> len_q == IW'(modbus_pkg::ECHO_LEN))
      else $error("echo reply length wrong");

   a_bcast_quiet: assert property (
      tx_valid_o |-> !bcast_q)
      else $error("reply sent to broadcast");

   a_bad_drop: assert property (
      state_q == modbus_pkg::S_EVAL && !frame_ok
      |=> (state_q == modbus_pkg::S_RX && !tx_valid_o) [*2])
      else $error("bad frame not dropped");

   c_read_reply: cover property (
      state_q == modbus_pkg::S_RD ##[1:200] tx_last_o);
   c_exception: cover property (tx_valid_o && exc_q);
   c_bcast_write: cover property (reg_we_o && bcast_q);
   c_multi_write: cover property (
      reg_we_o ##1 reg_we_o ##1 state_q == modbus_pkg::S_SEND);

endmodule

// File: rtu_master_model.sv
// Purpose: Reply sink of the bus master, with random stalls
// Assumes: Reply bytes come on the engine clock
// Notes:   Checks the CRC of each reply it receives
`timescale 1ns/1ns
module rtu_master_model (
   input  wire logic       clock_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_last_i,
   output logic            tx_ready_o
);
   logic [7:0]  got [$];
   logic [15:0] c;
   int          n_bad;

   // ----------------------------------------
   // Sink with stalls; stalls test the hold
   // ----------------------------------------
   initial begin
      tx_ready_o = 1'b0;
      c = 16'hFFFF;
      n_bad = 0;
   end

   always @(posedge clock_i) begin
      tx_ready_o <= #1 (($urandom % 4) != 0);
      if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
         got.push_back(tx_data_i);
         c = c ^ {8'h00, tx_data_i};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
         if (tx_last_i === 1'b1) begin
            if (c !== 16'h0000) n_bad++;
            c = 16'hFFFF;
         end
      end
   end
endmodule

// File: modbus_rtu_slave_handler_tb_top.sv
// Purpose: Self-checking bench of the RTU slave engine
// Assumes: Register file modelled here, read combinationally
// Notes:   Station address 01, zeroed for the last frame; MAX_REGS cut to 4
`timescale 1ns/1ns
module modbus_rtu_slave_handler_tb_top;
   localparam int NREG = 4;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        rx_valid_i = 1'b0;
   logic [7:0]  rx_data_i = 8'h00;
   logic        rx_end_i = 1'b0;
   logic        tx_valid_o, tx_last_o, tx_ready_i;
   logic        reg_we_o, reg_re_o, crc_err_o;
   logic [7:0]  tx_data_o;
   logic [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
   logic [15:0] mem [16];
   logic [31:0] wlog [$];
   logic [7:0]  cmd [$];
   logic [7:0]  exp [$];
   logic [7:0]  s;
   logic [15:0] w;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          n_crc = 0;
   int          n_rd = 0;
   int          r0 = 0;
   logic [7:0]  station = 8'h01;

   always #2 clock_i = ~clock_i;
   assign reg_rdata_i = mem[reg_addr_o[3:0]];

   modbus_rtu_slave_handler #(.MAX_REGS(NREG)) u_modbus_rtu_slave_handler (
      .clock_i(clock_i), .reset_i(reset_i), .station_addr_i(station),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_end_i(rx_end_i),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
      .tx_ready_i(tx_ready_i), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o),
      .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
      .reg_rdata_i(reg_rdata_i), .crc_err_o(crc_err_o));

   rtu_master_model u_rtu_master_model (
      .clock_i(clock_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));

   always @(posedge clock_i) begin
      if (crc_err_o === 1'b1) n_crc++;
      if (reg_re_o === 1'b1) n_rd++;
      if (reg_we_o === 1'b1) begin
         wlog.push_back({reg_addr_o, reg_wdata_o});
         mem[reg_addr_o[3:0]] <= reg_wdata_o;
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic give_verdict();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Regression OK");
      end
      else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
   endtask

   // Independent CRC, not the design's function
   task automatic seal(ref logic [7:0] q [$], input bit bad);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      c = c ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endtask

   task automatic send(input bit bad);
      seal(cmd, bad);
      foreach (cmd[i]) begin
         @(posedge clock_i) #1;
         rx_valid_i = 1'b1;
         rx_data_i = cmd[i];
      end
      @(posedge clock_i) #1;
      rx_valid_i = 1'b0;
      rx_end_i = 1'b1;
      @(posedge clock_i) #1;
      rx_end_i = 1'b0;
   endtask

   // Empty exp means no reply may come
   task automatic check_reply();
      int k;
      k = 0;
      while (k < 300 && (exp.size() == 0 ||
             u_rtu_master_model.got.size() < exp.size())) begin
         @(posedge clock_i);
         k++;
      end
      if (u_rtu_master_model.got.size() < exp.size()) begin
         n_mismatch++;
         give_verdict();
      end
      // Let stray extra bytes arrive before the count is compared
      repeat (8) @(posedge clock_i);
      cmp(u_rtu_master_model.got.size(), exp.size());
      foreach (exp[i]) begin
         if (i < u_rtu_master_model.got.size())
            cmp({24'h0, u_rtu_master_model.got[i]}, {24'h0, exp[i]});
      end
      u_rtu_master_model.got.delete();
      exp.delete();
      cmd.delete();
      repeat (4) @(posedge clock_i);
   endtask

   task automatic check_write(input logic [15:0] a, input logic [15:0] d);
      logic [31:0] x;
      x = 32'h0;
      if (wlog.size() != 0) x = wlog.pop_front();
      cmp(x, {a, d});
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(21));
      foreach (mem[i]) mem[i] = $urandom;
      repeat (12) @(posedge clock_i);
      #1 reset_i = 1'b0;
      cmd = '{8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h03};
      exp = '{8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h03, 8'h98, 8'h0B};
      send(1'b0);
      check_reply();
      check_write(16'h0001, 16'h0003);
      w = $urandom;
      cmd = '{8'h01, 8'h08, 8'h00, 8'h00, w[15:8], w[7:0]};
      send(1'b0);
      exp = cmd;
      check_reply();
      for (int t = 1; t <= NREG; t++) begin
         s = $urandom % 8;
         cmd = '{8'h01, 8'h03, 8'h00, s, 8'h00, t[7:0]};
         exp = '{8'h01, 8'h03, 8'(2 * t)};
         for (int i = 0; i < t; i++) begin
            exp.push_back(mem[s + i][15:8]);
            exp.push_back(mem[s + i][7:0]);
         end
         seal(exp, 1'b0);
         r0 = n_rd;
         send(1'b0);
         check_reply();
         cmp(n_rd - r0, t);
      end
      s = $urandom % 8;
      cmd = '{8'h01, 8'h10, 8'h00, s, 8'h00, 8'(NREG), 8'(2 * NREG)};
      for (int i = 0; i < NREG; i++) begin
         cmd.push_back(8'(s + 8'h51 * i));
         cmd.push_back(8'(i + 8'h3C));
      end
      exp = '{8'h01, 8'h10, 8'h00, s, 8'h00, 8'(NREG)};
      seal(exp, 1'b0);
      send(1'b0);
      check_reply();
      for (int i = 0; i < NREG; i++) begin
         check_write(16'(s + i), {8'(s + 8'h51 * i), 8'(i + 8'h3C)});
      end
      cmd = '{8'h01, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01};
      exp = '{8'h01, 8'h85, 8'h01};
      seal(exp, 1'b0);
      send(1'b0);
      check_reply();
      cmd = '{8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h04, 8'h12, 8'h34};
      exp = '{8'h01, 8'h90, 8'h03};
      seal(exp, 1'b0);
      send(1'b0);
      check_reply();
      cmd = '{8'h01, 8'h06, 8'h00, 8'h02, 8'h55, 8'hAA};
      send(1'b1);
      check_reply();
      cmp(n_crc, 1);
      cmd = '{8'h02, 8'h06, 8'h00, 8'h02, 8'h55, 8'hAA};
      send(1'b0);
      check_reply();
      cmp(wlog.size(), 0);
      cmd = '{8'h00, 8'h06, 8'h00, 8'h03, w[7:0], w[15:8]};
      send(1'b0);
      check_reply();
      check_write(16'h0003, {w[7:0], w[15:8]});
      // Own address zero silences the engine, broadcasts included
      #1 station = 8'h00;
      cmd = '{8'h00, 8'h06, 8'h00, 8'h04, 8'h12, 8'h34};
      send(1'b0);
      check_reply();
      cmp(wlog.size(), 0);
      cmp(u_rtu_master_model.n_bad, 0);
      give_verdict();
   end
endmodule
